// File: verilog/duart_pkg.sv
// Purpose: shared constants and carriers for the channel A mode/irq block
// Assumes: 32-bit APB, one register per aligned word
// Notes: all reset values are zero
`default_nettype none
package duart_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_COMMAND = 8'h08;
   localparam logic [7:0] OFF_AUX = 8'h10;
   localparam logic [7:0] OFF_IN_CHG = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
   localparam logic [7:0] OFF_PRE_HI = 8'h20;
   localparam logic [7:0] OFF_PRE_LO = 8'h24;
   localparam logic [7:0] OFF_PIN_CFG = 8'h28;
   localparam logic [7:0] OFF_OUT_SET = 8'h2c;
   localparam logic [7:0] OFF_OUT_CLR = 8'h30;
   localparam logic [7:0] REG_RESET = 8'h00;
   // first mode register fields
   localparam int MR1_RTS = 7;
   localparam int MR1_RXINT = 6;
   localparam int MR1_ERRMODE = 5;
   localparam int MR1_PAR_HI = 4;
   localparam int MR1_PAR_LO = 3;
   localparam int MR1_PTYPE = 2;
   localparam int MR1_BITS_HI = 1;
   localparam logic [3:0] DATA_BITS_MIN = 4'h5;
   // aux control and pin config fields
   localparam int ACR_BRG = 7;
   localparam int ACR_CT_HI = 6;
   localparam int ACR_CT_LO = 4;
   localparam int PINCFG_PIN4 = 4;
   // command misc field and codes
   localparam int CMD_HI = 7;
   localparam int CMD_LO = 4;
   localparam logic [3:0] CMD_SET_PTR = 4'h1;
   localparam logic [3:0] CMD_RESET_ERR = 4'h4;
   // interrupt status bit positions
   localparam int IRQ_TXA = 0;
   localparam int IRQ_RXA = 1;
   localparam int IRQ_BRKA = 2;
   localparam int IRQ_CTR = 3;
   localparam int IRQ_TXB = 4;
   localparam int IRQ_RXB = 5;
   localparam int IRQ_BRKB = 6;
   localparam int IRQ_INCHG = 7;
   typedef enum logic [1:0] {
      PAR_WITH = 2'b00,
      PAR_FORCE = 2'b01,
      PAR_NONE = 2'b10,
      PAR_MULTI = 2'b11
   } par_mode_type;
   typedef enum logic {
      PTR_FIRST = 1'b0,
      PTR_SECOND = 1'b1
   } mr_ptr_type;
   typedef struct packed {
      logic start_valid;
      logic fifo_full;
      logic rx_ready;
      logic overrun;
      logic tx_empty;
      logic tx_ready;
      logic top_break;
      logic top_framing;
      logic top_parity;
   } rx_side_type;
   typedef struct packed {
      logic brk_delta_a;
      logic brk_delta_b;
      logic rx_src_b;
      logic tx_ready_b;
      logic counter_ready;
   } irq_src_type;
   typedef struct packed {
      logic parity_en;
      logic parity_forced;
      logic parity_type;
      logic multidrop;
      logic ad_polarity;
      logic [3:0] data_bits;
   } char_format_type;
   typedef struct packed {
      logic brg_set2;
      logic [2:0] ct_mode;
      logic [15:0] preload;
   } timer_cfg_type;
endpackage
`default_nettype wire

// File: verilog/input_change_cell.sv
// Purpose: change detector with sticky flag for one input pin
// Assumes: level is synchronous to pclk
// Notes: first edge after reset only arms, so no false change
`timescale 1ns/100ps
`default_nettype none
module input_change_cell (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic level,
   input wire logic clear,
   output logic delta_q
);
   logic prev_q;
   logic armed_q;
   logic delta_d;
   wire changed = armed_q & (level != prev_q);
   // set beats a clear in the same cycle
   assign delta_d = changed | (delta_q & ~clear);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b0;
         armed_q <= 1'b0;
         delta_q <= 1'b0;
      end else begin
         prev_q <= level;
         armed_q <= 1'b1;
         delta_q <= delta_d;
      end
   end
endmodule // input_change_cell
`default_nettype wire

// File: verilog/duart_chan_regs.sv
// Purpose: channel A first mode register, aux, change, irq, preload regs
// Assumes: APB slave, zero wait states, receiver status on rx port
// Notes: read data is captured in the setup cycle
// Operation
// - pointer starts at first mode reg; any access moves it to second
// - with rts control set, start bit into full fifo negates rts
// - auto negation keeps output bit 0; rts returns when fifo frees
// - bit 6 picks receiver-ready or fifo-full as receive irq source
// - selected receive status drives pin 4 when configured as irq
// - char mode: error bits show only the fifo top character
// - block mode: error bits OR every top character until reset-error
// - with or forced parity: parity appended and checked
// - parity field 11 selects multidrop mode
// - parity type sets odd/even or forced level; ignored without parity
// - in multidrop parity type sets address/data bit polarity
// - bits field sets data bits, start/parity/stop not counted
// - aux bit 7 selects baud set one or two
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module duart_chan_regs #(
   parameter int N_CHG = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire duart_pkg::rx_side_type rx,
   input wire duart_pkg::irq_src_type src,
   input wire logic [N_CHG-1:0] in_pins,
   output duart_pkg::char_format_type fmt,
   output duart_pkg::timer_cfg_type tmr,
   output logic [7:0] chan_a_mode_second,
   output logic [7:0] out_pins,
   output logic irq
);
   import duart_pkg::*;

   generate
      if (N_CHG < 1 || N_CHG > 4) begin : g_bad
         $error("N_CHG must be 1 to 4");
      end
   endgenerate

   // bus phases
   wire setup = psel & ~penable;
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;

   // address decode
   wire hit_mode = paddr == OFF_MODE;
   wire hit_stat = paddr == OFF_STATUS;
   wire hit_cmd = paddr == OFF_COMMAND;
   wire hit_aux = paddr == OFF_AUX;
   wire hit_chg = paddr == OFF_IN_CHG;
   wire hit_isr = paddr == OFF_IRQ_STAT;
   wire hit_imr = paddr == OFF_IRQ_MASK;
   wire hit_phi = paddr == OFF_PRE_HI;
   wire hit_plo = paddr == OFF_PRE_LO;
   wire hit_cfg = paddr == OFF_PIN_CFG;
   wire hit_set = paddr == OFF_OUT_SET;
   wire hit_clr = paddr == OFF_OUT_CLR;
   wire mapped = hit_mode | hit_stat | hit_cmd | hit_aux | hit_chg |
      hit_isr | hit_imr | hit_phi | hit_plo | hit_cfg | hit_set | hit_clr;

   // registers
   mr_ptr_type ptr_q, ptr_d;
   logic [7:0] mr1_q, mr2_q, acr_q, imr_q, isr_q, isr_d;
   logic [7:0] phi_q, plo_q, output_pin_config_q, opr_q, opr_d;
   logic [2:0] err_acc_q, err_acc_d;
   logic rts_block_q, rts_block_d;
   logic [31:0] prdata_q;
   logic [3:0] delta_all;
   logic [3:0] level_all;

   // commands
   wire [3:0] misc = pwdata[CMD_HI:CMD_LO];
   wire cmd_wr = wr & hit_cmd;
   wire set_ptr = cmd_wr & (misc == CMD_SET_PTR);
   wire clr_err = cmd_wr & (misc == CMD_RESET_ERR);

   // mode pointer; the command and a mode access never share a cycle
   wire mode_acc = acc & hit_mode;
   wire mr1_wr = wr & hit_mode & (ptr_q == PTR_FIRST);
   wire mr2_wr = wr & hit_mode & (ptr_q == PTR_SECOND);
   assign ptr_d = set_ptr ? PTR_FIRST :
      (mode_acc ? PTR_SECOND : ptr_q);
   wire [7:0] mode_rd = (ptr_q == PTR_FIRST) ? mr1_q : mr2_q;

   // character format
   par_mode_type pmode;
   assign pmode = par_mode_type'(mr1_q[MR1_PAR_HI:MR1_PAR_LO]);
   wire par_on = (pmode == PAR_WITH) | (pmode == PAR_FORCE);
   assign fmt.parity_en = par_on;
   assign fmt.parity_forced = pmode == PAR_FORCE;
   assign fmt.parity_type = par_on & mr1_q[MR1_PTYPE];
   assign fmt.multidrop = pmode == PAR_MULTI;
   assign fmt.ad_polarity = fmt.multidrop & mr1_q[MR1_PTYPE];
   assign fmt.data_bits = DATA_BITS_MIN +
      {2'b00, mr1_q[MR1_BITS_HI:0]};
   assign chan_a_mode_second = mr2_q;

   // timer and baud set
   assign tmr.brg_set2 = acr_q[ACR_BRG];
   assign tmr.ct_mode = acr_q[ACR_CT_HI:ACR_CT_LO];
   assign tmr.preload = {phi_q, plo_q};

   // receive irq source
   wire rx_src_a = mr1_q[MR1_RXINT] ? rx.fifo_full : rx.rx_ready;

   // error status; top bits only count while a character is there
   wire [2:0] top_err = rx.rx_ready ?
      {rx.top_break, rx.top_framing, rx.top_parity} : 3'b000;
   wire blk_mode = mr1_q[MR1_ERRMODE];
   // accumulation runs in block mode only, set beats the reset command
   assign err_acc_d = (clr_err ? 3'b000 : err_acc_q) |
      (blk_mode ? top_err : 3'b000);
   wire [2:0] err_shown = blk_mode ? (err_acc_q | top_err) : top_err;
   wire [7:0] chan_status = {err_shown, rx.overrun, rx.tx_empty,
      rx.tx_ready, rx.fifo_full, rx.rx_ready};

   // receiver flow control; output bit 0 itself is never touched here
   wire rts_hit = mr1_q[MR1_RTS] & rx.start_valid & rx.fifo_full;
   assign rts_block_d = rx.fifo_full & (rts_block_q | rts_hit);
   wire out_pin_0 = ~(opr_q[0] & ~rts_block_q);
   wire chan_a_request_to_send_n = out_pin_0;
   wire out_pin_4 = output_pin_config_q[PINCFG_PIN4] ? ~rx_src_a : ~opr_q[4];
   // pins drive the inverse of the output bits, except pin 4 when configured as irq and pin 0 while rts is blocked
   assign out_pins = {~opr_q[7:5], out_pin_4, ~opr_q[3:1],
      chan_a_request_to_send_n};

   // output port bit set and reset
   wire [7:0] opr_set = (wr & hit_set) ? pwdata[7:0] : 8'h00;
   wire [7:0] opr_clr = (wr & hit_clr) ? pwdata[7:0] : 8'h00;
   assign opr_d = (opr_q & ~opr_clr) | opr_set;

   // input change detectors
   wire chg_clear = rd & hit_chg;
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_chg
         if (i < N_CHG) begin : g_on
            input_change_cell u_cell (
               .pclk(pclk),
               .presetn(presetn),
               .level(in_pins[i]),
               .clear(chg_clear),
               .delta_q(delta_all[i])
            );
            assign level_all[i] = in_pins[i];
         end else begin : g_off
            assign delta_all[i] = 1'b0;
            assign level_all[i] = 1'b0;
         end
      end
   endgenerate
   wire in_chg = |(delta_all & acr_q[3:0]);

   // sticky status; a new event wins over the write-one clear
   wire [7:0] events = {in_chg, src.brk_delta_b, src.rx_src_b,
      src.tx_ready_b, src.counter_ready, src.brk_delta_a, rx_src_a,
      rx.tx_ready};
   wire [7:0] isr_w1c = (wr & hit_isr) ? pwdata[7:0] : 8'h00;
   assign isr_d = events | (isr_q & ~isr_w1c);
   assign irq = |(isr_q & imr_q);

   // read mux; write-only registers read as zero
   wire [7:0] rd_byte =
      hit_mode ? mode_rd :
      hit_stat ? chan_status :
      hit_chg ? {delta_all, level_all} :
      hit_isr ? isr_q : 8'h00;
   wire [31:0] prdata_d = setup ? {24'h000000, rd_byte} : prdata_q;
   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_q <= PTR_FIRST;
         mr1_q <= REG_RESET;
         mr2_q <= REG_RESET;
      end else begin
         ptr_q <= ptr_d;
         if (mr1_wr) mr1_q <= pwdata[7:0];
         if (mr2_wr) mr2_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acr_q <= REG_RESET;
         imr_q <= REG_RESET;
         phi_q <= REG_RESET;
         plo_q <= REG_RESET;
         output_pin_config_q <= REG_RESET;
      end else begin
         if (wr & hit_aux) acr_q <= pwdata[7:0];
         if (wr & hit_imr) imr_q <= pwdata[7:0];
         if (wr & hit_phi) phi_q <= pwdata[7:0];
         if (wr & hit_plo) plo_q <= pwdata[7:0];
         if (wr & hit_cfg) output_pin_config_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isr_q <= REG_RESET;
         opr_q <= REG_RESET;
         err_acc_q <= 3'b000;
         rts_block_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         isr_q <= isr_d;
         opr_q <= opr_d;
         err_acc_q <= err_acc_d;
         rts_block_q <= rts_block_d;
         prdata_q <= prdata_d;
      end
   end

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence first_access_s;
      mode_acc && ptr_q == PTR_FIRST;
   endsequence

   sequence blocked_start_s;
      mr1_q[MR1_RTS] && rx.start_valid && rx.fifo_full &&
         !(wr && (hit_set || hit_clr));
   endsequence

   sequence err_seen_s;
      blk_mode && rx.rx_ready && rx.top_framing && !clr_err;
   endsequence

   ptr_advance_a: assert property (
      first_access_s |=> ptr_q == PTR_SECOND && mode_rd == mr2_q)
      else $error("mode pointer did not advance");

   ptr_reset_a: assert property (
      set_ptr |=> (ptr_q == PTR_FIRST) and
         (!mode_acc |=> ptr_q == PTR_FIRST))
      else $error("mode pointer not back at first");

   rts_negate_a: assert property (
      blocked_start_s |=> out_pin_0 && opr_q[0] == $past(opr_q[0]))
      else $error("rts not negated on full fifo");

   rts_return_a: assert property (
      rts_block_q && !rx.fifo_full && opr_q[0] && !(wr & hit_clr)
      |=> !out_pin_0)
      else $error("rts not reasserted after fifo freed");

   rx_source_a: assert property (
      !mr1_q[MR1_RXINT] && rx.rx_ready |=> isr_q[IRQ_RXA])
      else $error("receiver ready did not raise receive status");

   pin4_irq_a: assert property (
      output_pin_config_q[PINCFG_PIN4] && mr1_q[MR1_RXINT] |->
         out_pin_4 == !rx.fifo_full)
      else $error("pin 4 does not follow fifo full");

   char_err_a: assert property (
      !blk_mode && rx.rx_ready |-> chan_status[7:5] ==
         {rx.top_break, rx.top_framing, rx.top_parity})
      else $error("char mode error bits not from fifo top");

   block_err_a: assert property (
      err_seen_s ##1 (blk_mode && !clr_err) [*2] |-> chan_status[6])
      else $error("block mode lost a framing error");

   parity_cfg_a: assert property (
      pmode == PAR_NONE |-> !fmt.parity_en && !fmt.parity_type)
      else $error("parity active in no-parity mode");

   multidrop_a: assert property (
      pmode == PAR_MULTI |-> fmt.multidrop && !fmt.parity_en &&
         fmt.ad_polarity == mr1_q[MR1_PTYPE])
      else $error("multidrop polarity wrong");

   data_bits_a: assert property (
      $rose(mr1_wr) |=> fmt.data_bits ==
         DATA_BITS_MIN + {2'b00, $past(pwdata[1:0])})
      else $error("data bit count wrong");

   irq_level_a: assert property (
      |(isr_q & imr_q) |-> irq ##1 (irq || $past(isr_w1c != 0) ||
         $past(wr & hit_imr)))
      else $error("interrupt dropped while status pending");

   chg_flag_a: assert property (
      acr_q[0] && delta_all[0] && !chg_clear |=> isr_q[IRQ_INCHG])
      else $error("input change did not raise status");

   mdrop_off_a: assert property (
      pmode != PAR_MULTI |-> !fmt.multidrop && !fmt.ad_polarity)
      else $error("multidrop active outside parity code 11");

   parity_type_a: assert property (
      pmode == PAR_WITH || pmode == PAR_FORCE |->
         fmt.parity_en && fmt.parity_type == mr1_q[MR1_PTYPE])
      else $error("parity type not taken from mode bit 2");

   baud_set_a: assert property (
      wr && hit_aux |=> tmr.brg_set2 == $past(pwdata[ACR_BRG]))
      else $error("baud set select not taken from aux bit 7");

   // flow control must never alter the output bits themselves
   out_bits_kept_a: assert property (
      !(wr && (hit_set || hit_clr)) |=> opr_q == $past(opr_q))
      else $error("output bits changed without a bus command");

   rts_hold_a: assert property (
      !rts_block_q && !(mr1_q[MR1_RTS] && rx.start_valid) |=>
         !rts_block_q)
      else $error("rts blocked without a start bit under control");

   pin4_plain_a: assert property (
      !output_pin_config_q[PINCFG_PIN4] |-> out_pin_4 == !opr_q[4])
      else $error("pin 4 does not follow its output bit");

   char_empty_a: assert property (
      !blk_mode && !rx.rx_ready |-> chan_status[7:5] == 3'b000)
      else $error("char mode error bits shown with no character");

   irq_quiet_a: assert property (
      !(|(isr_q & imr_q)) |-> !irq)
      else $error("interrupt high with no unmasked status");

   // a change in the clearing cycle would win, so pins must hold
   chg_clear_a: assert property (
      chg_clear && $stable(in_pins) |=> delta_all == 4'h0)
      else $error("change flags not cleared by read");

endmodule // duart_chan_regs
`default_nettype wire

// File: dv/rx_feed_model.sv
// Purpose: remote transmitter feeding the channel receiver status
// Assumes: four-deep receive fifo, one character per start bit
// Notes: top-character error flags come from the bench
`timescale 1ns/100ps
`default_nettype none
module rx_feed_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cts_n,
   input wire logic send,
   input wire logic pop,
   input wire logic [5:0] flags,
   output duart_pkg::rx_side_type rx
);
   import duart_pkg::*;
   int count;
   logic strobe_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 0;
         strobe_q <= 1'b0;
      end else begin
         // sends only while clear-to-send is low
         strobe_q <= send && !cts_n;
         if (pop && count > 0)
            count <= count - 1;
         // a start bit into a full fifo is lost, as on a real line
         else if (strobe_q && count < 4)
            count <= count + 1;
      end
   end
   always_comb begin
      rx = '0;
      rx.start_valid = strobe_q;
      rx.fifo_full = (count == 4);
      rx.rx_ready = (count != 0);
      rx.overrun = flags[5];
      rx.tx_empty = flags[4];
      rx.tx_ready = flags[3];
      rx.top_break = flags[2];
      rx.top_framing = flags[1];
      rx.top_parity = flags[0];
   end
endmodule // rx_feed_model
`default_nettype wire

// File: dv/duart_channel_mode1_and_irq_regs_tb.sv
// Purpose: self-checking bench for the channel mode and irq registers
// Assumes: zero-wait apb slave, partner feeds receiver status
// Notes: expected values worked out here from field layouts
`timescale 1ns/100ps
`default_nettype none
module duart_channel_mode1_and_irq_regs_tb;
   import duart_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, send, pop, pready, pslverr;
   logic irq, err;
   logic [7:0] paddr, out_pins, mode2, e;
   logic [31:0] pwdata, prdata, r;
   logic [5:0] flags;
   logic [3:0] in_pins, old;
   rx_side_type rx;
   irq_src_type src;
   char_format_type fmt;
   timer_cfg_type tmr;
   int mismatches, comparisons, v, en;

   duart_chan_regs #(.N_CHG(4)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx(rx), .src(src), .in_pins(in_pins),
      .fmt(fmt), .tmr(tmr), .chan_a_mode_second(mode2),
      .out_pins(out_pins), .irq(irq));
   rx_feed_model feed (.pclk(pclk), .presetn(presetn),
      .cts_n(out_pins[0]), .send(send), .pop(pop), .flags(flags),
      .rx(rx));

   task automatic chk(input string name, input logic [31:0] seen,
         input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask

   // entered just after an edge; one idle cycle follows each transfer
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wmode(input logic [7:0] m);
      apb(1'b1, OFF_COMMAND, {CMD_SET_PTR, 4'h0});
      apb(1'b1, OFF_MODE, m);
   endtask

   task automatic push();
      send <= 1'b1;
      @(posedge pclk);
      send <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic popc();
      pop <= 1'b1;
      @(posedge pclk);
      pop <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic give_verdict();
      if (mismatches == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      give_verdict();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      send = 1'b0;
      pop = 1'b0;
      flags = 6'h00;
      in_pins = 4'h0;
      src = '0;
      mismatches = 0;
      comparisons = 0;
      void'($urandom(33391));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("pins", out_pins, 8'hff);
      chk("irq", irq, 1'b0);
      apb(1'b0, OFF_MODE, 8'h00);
      chk("mode1", r, 32'h0);
      apb(1'b0, OFF_AUX, 8'h00);
      chk("aux", r, 32'h0);
      apb(1'b0, 8'h0c, 8'h00);
      chk("unmapped", {r[30:0], err}, 32'h1);
      apb(1'b1, OFF_MODE, 8'h5a);
      chk("mode2", mode2, 8'h5a);
      wmode(8'h1b);
      apb(1'b0, OFF_MODE, 8'h00);
      chk("ptr2", r, 32'h5a);
      apb(1'b1, OFF_COMMAND, {CMD_SET_PTR, 4'h0});
      apb(1'b0, OFF_MODE, 8'h00);
      chk("ptr1", r, 32'h1b);
      apb(1'b0, OFF_MODE, 8'h00);
      chk("ptr adv", r, 32'h5a);
      for (int i = 0; i < 32; i++) begin
         v = ($urandom_range(7, 0) << 5) | i;
         wmode(v[7:0]);
         chk("par_en", fmt.parity_en, i[4:3] < 2);
         chk("forced", fmt.parity_forced, i[4:3] == 1);
         chk("multi", fmt.multidrop, i[4:3] == 3);
         if (i[4:3] < 2)
            chk("ptype", fmt.parity_type, i[2]);
         if (i[4:3] == 3)
            chk("adpol", fmt.ad_polarity, i[2]);
         chk("bits", fmt.data_bits, 5 + i[1:0]);
      end
      repeat (3) begin
         v = $urandom_range(255, 0);
         apb(1'b1, OFF_AUX, v[7:0]);
         apb(1'b1, OFF_PRE_HI, v[7:0] ^ 8'h3c);
         apb(1'b1, OFF_PRE_LO, ~v[7:0]);
         chk("brg", tmr.brg_set2, v[7]);
         chk("ctmode", tmr.ct_mode, v[6:4]);
         chk("preload", tmr.preload, {v[7:0] ^ 8'h3c, ~v[7:0]});
      end
      apb(1'b1, OFF_AUX, 8'h00);
      apb(1'b1, OFF_IRQ_MASK, 8'hff);
      repeat (4) begin
         v = $urandom_range(31, 1);
         src <= irq_src_type'(v[4:0]);
         @(posedge pclk);
         src <= '0;
         e = {1'b0, v[3], v[2], v[1], v[0], v[4], 2'b00};
         apb(1'b0, OFF_IRQ_STAT, 8'h00);
         chk("isr", r, {24'h0, e});
         chk("irq set", irq, 1'b1);
         apb(1'b1, OFF_IRQ_MASK, ~e);
         chk("irq masked", irq, 1'b0);
         apb(1'b1, OFF_IRQ_STAT, 8'hff);
         apb(1'b1, OFF_IRQ_MASK, 8'hff);
         chk("irq clr", irq, 1'b0);
      end
      repeat (4) begin
         v = $urandom_range(15, 0);
         en = $urandom_range(15, 0);
         old = in_pins;
         apb(1'b1, OFF_AUX, en[7:0]);
         in_pins <= v[3:0];
         repeat (2) @(posedge pclk);
         e = {v[3:0] ^ old, v[3:0]};
         apb(1'b0, OFF_IRQ_STAT, 8'h00);
         chk("chg isr", r, {24'h0, |(e[7:4] & en[3:0]), 7'h0});
         apb(1'b0, OFF_IN_CHG, 8'h00);
         chk("chg", r, {24'h0, e});
         apb(1'b0, OFF_IN_CHG, 8'h00);
         chk("chg clr", r, {28'h0, v[3:0]});
         apb(1'b1, OFF_IRQ_STAT, 8'hff);
      end
      apb(1'b1, OFF_OUT_SET, 8'h01);
      chk("rts on", out_pins[0], 1'b0);
      wmode(8'h80);
      repeat (4) push();
      chk("rts full", out_pins[0], 1'b0);
      push();
      chk("rts off", out_pins[0], 1'b1);
      push();
      popc();
      chk("rts back", out_pins[0], 1'b0);
      push();
      wmode(8'h00);
      push();
      chk("rts no ctl", out_pins[0], 1'b0);
      repeat (3) popc();
      apb(1'b1, OFF_PIN_CFG, 8'h10);
      apb(1'b1, OFF_IRQ_MASK, 8'h02);
      apb(1'b1, OFF_IRQ_STAT, 8'hff);
      chk("receiver_ready_flag irq", irq, 1'b1);
      chk("pin4 rdy", out_pins[4], 1'b0);
      wmode(8'h40);
      apb(1'b1, OFF_IRQ_STAT, 8'hff);
      chk("fifo_full_flag irq", irq, 1'b0);
      chk("pin4 full", out_pins[4], 1'b1);
      repeat (3) push();
      chk("fifo_full_flag set", irq, 1'b1);
      chk("pin4 set", out_pins[4], 1'b0);
      repeat (3) popc();
      flags <= 6'b000101;
      apb(1'b0, OFF_STATUS, 8'h00);
      chk("char st", r, 32'ha1);
      flags <= 6'b000010;
      apb(1'b0, OFF_STATUS, 8'h00);
      chk("char st2", r, 32'h41);
      wmode(8'h20);
      apb(1'b1, OFF_COMMAND, {CMD_RESET_ERR, 4'h0});
      flags <= 6'b000001;
      apb(1'b0, OFF_STATUS, 8'h00);
      chk("block or", r, 32'h61);
      apb(1'b1, OFF_COMMAND, {CMD_RESET_ERR, 4'h0});
      apb(1'b0, OFF_STATUS, 8'h00);
      chk("block clr", r, 32'h21);
      flags <= 6'b111000;
      apb(1'b1, OFF_IRQ_MASK, 8'h01);
      apb(1'b0, OFF_STATUS, 8'h00);
      chk("tx st", r, 32'h3d);
      chk("tx irq", irq, 1'b1);
      apb(1'b1, OFF_PIN_CFG, 8'h00);
      apb(1'b1, OFF_OUT_SET, 8'hf0);
      chk("pin4 plain", out_pins[4], 1'b0);
      apb(1'b1, OFF_OUT_CLR, 8'h30);
      chk("pins clr", out_pins, 8'h3e);
      // mid-run reset: pointer must be back at the first mode register
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("rst pins", out_pins, 8'hff);
      chk("rst irq", irq, 1'b0);
      apb(1'b1, OFF_MODE, 8'h03);
      chk("rst ptr", fmt.data_bits, 4'h8);
      chk("rst mode2", mode2, 8'h00);
      apb(1'b0, OFF_IN_CHG, 8'h00);
      chk("rst chg", r[7:4], 4'h0);
      give_verdict();
   end
endmodule // duart_channel_mode1_and_irq_regs_tb
`default_nettype wire
